// file: hw/rdc_pkg.sv
/*
 Package for the relay drive control block: register offsets,
 field positions, reset values and carrier types.
 Assumes a single synchronous clock domain and a plain register port.
*/
package rdc_pkg;
    localparam int          RELAY_COUNT   = 4;
    localparam int          ADDR_W        = 4;
    localparam logic [3:0]  ADDR_RELAY1   = 4'h0;
    localparam logic [3:0]  ADDR_RELAY2   = 4'h1;
    localparam logic [3:0]  ADDR_RELAY3   = 4'h2;
    localparam logic [3:0]  ADDR_RELAY4   = 4'h3;
    localparam logic [3:0]  ADDR_ALL      = 4'h4;
    localparam logic [3:0]  ADDR_PENDING  = 4'h5;
    localparam logic [3:0]  ADDR_LIST     = 4'h6;
    localparam int          FIELD_VALUE   = 0;
    localparam logic [3:0]  RELAY_RESET   = 4'h0;
    localparam logic [31:0] READ_UNMAPPED = 32'h00000000;

    typedef struct packed {
        logic        write;
        logic        read;
        logic [3:0]  addr;
        logic [31:0] wdata;
    } rdc_bus_t;

    typedef struct packed {
        logic       edit;
        logic [1:0] index;
        logic       value;
        logic       commit;
        logic       cancel;
    } rdc_panel_t;
endpackage

// file: hw/rdc_relay_driver_control.sv
/*
 Relay drive control: four relay bits, per-relay remote writes,
 staged front-panel edits with commit and cancel, state list readout.
 Assumes panel strobes come from logic on core_clk, one cycle long.
*/
// Our own choices: the strobed register port and the placing of the registers.
// Operation
// RULE1 - Four independent relay bits, separately changeable
// RULE2 - One energizes coil, zero de-energizes
// RULE3 - All relays open after reset
// RULE4 - Remote write per relay, one closes
// RULE5 - Panel edits staged, applied together on commit
// RULE6 - Cancel restores pending copy, outputs unchanged
// RULE7 - Readout lists index and value pairs
// RULE8 - Committed bits hold until changed
`timescale 1ns/1ps
module rdc_relay_driver_control (
    input  wire logic                     core_clk,
    input  wire logic                     reset,
    input  wire rdc_pkg::rdc_bus_t        bus,
    input  wire rdc_pkg::rdc_panel_t      panel,
    output logic [31:0]                   readData,
    output logic [3:0]                    relayDrive
);
    logic [3:0]  pending;
    logic [3:0]  next_drive;
    logic [3:0]  next_pending;
    logic [31:0] next_read;
    logic [11:0] pairList;
    logic        remoteHit;

    // Remote write decode
    always_comb begin
        next_drive = relayDrive;
        remoteHit  = 1'b0;
        if (bus.write) begin
            case (bus.addr)
                rdc_pkg::ADDR_RELAY1: begin
                    next_drive[0] = bus.wdata[rdc_pkg::FIELD_VALUE]; // see RULE4
                    remoteHit     = 1'b1;
                end
                rdc_pkg::ADDR_RELAY2: begin
                    next_drive[1] = bus.wdata[rdc_pkg::FIELD_VALUE]; // see RULE4
                    remoteHit     = 1'b1;
                end
                rdc_pkg::ADDR_RELAY3: begin
                    next_drive[2] = bus.wdata[rdc_pkg::FIELD_VALUE]; // see RULE4
                    remoteHit     = 1'b1;
                end
                rdc_pkg::ADDR_RELAY4: begin
                    next_drive[3] = bus.wdata[rdc_pkg::FIELD_VALUE]; // see RULE4
                    remoteHit     = 1'b1;
                end
                rdc_pkg::ADDR_ALL: begin
                    next_drive = bus.wdata[3:0];
                    remoteHit  = 1'b1;
                end
                default: begin
                    remoteHit = 1'b0;
                end
            endcase
        end
        if (panel.commit) begin
            next_drive = pending; // see RULE5
        end
    end

    // Drive register, one bit per relay, high energizes
    always_ff @(posedge core_clk) begin
        if (reset) begin
            relayDrive <= rdc_pkg::RELAY_RESET; // see RULE3
        end else begin
            relayDrive <= next_drive; // see RULE1, see RULE2, see RULE8
        end
    end

    // Pending copy of panel edits
    always_comb begin
        next_pending = pending;
        if (panel.cancel) begin
            next_pending = relayDrive; // see RULE6
        end else if (panel.edit) begin
            next_pending[panel.index] = panel.value; // see RULE5
        end else if (remoteHit && !panel.commit) begin
            next_pending = next_drive;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pending <= rdc_pkg::RELAY_RESET;
        end else begin
            pending <= next_pending;
        end
    end

    // Index and value pairs, relay 1 in lowest triple
    always_comb begin
        for (int i = 0; i < rdc_pkg::RELAY_COUNT; i++) begin
            pairList[i*3 +: 3] = {2'(i), relayDrive[i]}; // see RULE7
        end
    end

    always_comb begin
        next_read = rdc_pkg::READ_UNMAPPED;
        case (bus.addr)
            rdc_pkg::ADDR_RELAY1:  next_read = {31'h0, relayDrive[0]};
            rdc_pkg::ADDR_RELAY2:  next_read = {31'h0, relayDrive[1]};
            rdc_pkg::ADDR_RELAY3:  next_read = {31'h0, relayDrive[2]};
            rdc_pkg::ADDR_RELAY4:  next_read = {31'h0, relayDrive[3]};
            rdc_pkg::ADDR_ALL:     next_read = {28'h0, relayDrive};
            rdc_pkg::ADDR_PENDING: next_read = {28'h0, pending};
            rdc_pkg::ADDR_LIST:    next_read = {20'h0, pairList}; // see RULE7
            default:               next_read = rdc_pkg::READ_UNMAPPED;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            readData <= 32'h00000000;
        end else if (bus.read) begin
            readData <= next_read;
        end else begin
            readData <= 32'h00000000;
        end
    end

    // Reset checks
    a_reset_open: assert property (@(posedge core_clk) // see RULE3
        reset |=> relayDrive == 4'h0)
        else $error("relays not open after reset");
    a_pending_reset: assert property (@(posedge core_clk) // see RULE3
        reset |=> pending == 4'h0)
        else $error("pending not cleared by reset");

    // Remote write checks
    a_remote_r1: assert property (@(posedge core_clk) disable iff (reset) // see RULE4
        bus.write && bus.addr == rdc_pkg::ADDR_RELAY1 && !panel.commit
        |=> relayDrive[0] == $past(bus.wdata[0])
            && relayDrive[3:1] == $past(relayDrive[3:1]))
        else $error("relay 1 write touched wrong bit");
    a_remote_one: assert property (@(posedge core_clk) disable iff (reset) // see RULE4
        bus.write && bus.addr == rdc_pkg::ADDR_RELAY2 && !panel.commit
        |=> relayDrive[1] == $past(bus.wdata[0]) && relayDrive[0] == $past(relayDrive[0])
            && relayDrive[3:2] == $past(relayDrive[3:2]))
        else $error("relay write touched wrong bit");
    a_remote_r3: assert property (@(posedge core_clk) disable iff (reset) // see RULE4
        bus.write && bus.addr == rdc_pkg::ADDR_RELAY3 && !panel.commit
        |=> relayDrive[2] == $past(bus.wdata[0]) && relayDrive[3] == $past(relayDrive[3])
            && relayDrive[1:0] == $past(relayDrive[1:0]))
        else $error("relay 3 write touched wrong bit");
    a_remote_r4: assert property (@(posedge core_clk) disable iff (reset) // see RULE4
        bus.write && bus.addr == rdc_pkg::ADDR_RELAY4 && !panel.commit
        |=> relayDrive[3] == $past(bus.wdata[0])
            && relayDrive[2:0] == $past(relayDrive[2:0]))
        else $error("relay 4 write touched wrong bit");
    a_all_write: assert property (@(posedge core_clk) disable iff (reset) // see RULE4
        bus.write && bus.addr == rdc_pkg::ADDR_ALL && !panel.commit
        |=> relayDrive == $past(bus.wdata[3:0]))
        else $error("group write not applied");
    a_refused_write: assert property (@(posedge core_clk) disable iff (reset) // see RULE8
        bus.write && bus.addr > rdc_pkg::ADDR_ALL && !panel.commit
        |=> $stable(relayDrive))
        else $error("unmapped write changed drive");

    // Panel staging checks
    a_commit_apply: assert property (@(posedge core_clk) disable iff (reset) // see RULE5
        panel.commit |=> relayDrive == $past(pending))
        else $error("commit did not apply pending");
    a_edit_staged: assert property (@(posedge core_clk) disable iff (reset) // see RULE5
        panel.edit && !panel.commit && !bus.write |=> $stable(relayDrive))
        else $error("edit reached outputs early");
    a_edit_pending: assert property (@(posedge core_clk) disable iff (reset) // see RULE5
        panel.edit && !panel.cancel
        |=> pending[$past(panel.index)] == $past(panel.value))
        else $error("edit not held in pending");
    a_cancel_restore: assert property (@(posedge core_clk) disable iff (reset) // see RULE6
        panel.cancel && !panel.commit && !bus.write
        |=> pending == relayDrive && $stable(relayDrive))
        else $error("cancel did not restore");
    a_cancel_copy: assert property (@(posedge core_clk) disable iff (reset) // see RULE6
        panel.cancel |=> pending == $past(relayDrive))
        else $error("cancel did not copy drive");
    a_pending_refresh: assert property (@(posedge core_clk) disable iff (reset) // see RULE6
        bus.write && bus.addr <= rdc_pkg::ADDR_ALL
        && !panel.commit && !panel.edit && !panel.cancel
        |=> pending == relayDrive)
        else $error("pending not refreshed by remote write");

    // Hold check
    a_hold_drive: assert property (@(posedge core_clk) disable iff (reset) // see RULE8
        !bus.write && !panel.commit |=> $stable(relayDrive))
        else $error("drive changed without cause");

    // Readout checks
    a_list_pairs: assert property (@(posedge core_clk) disable iff (reset) // see RULE7
        bus.read && bus.addr == rdc_pkg::ADDR_LIST
        |=> readData[11:9] == {2'h3, $past(relayDrive[3])}
            && readData[2:0] == {2'h0, $past(relayDrive[0])})
        else $error("pair list wrong");
    a_list_mid: assert property (@(posedge core_clk) disable iff (reset) // see RULE7
        bus.read && bus.addr == rdc_pkg::ADDR_LIST
        |=> readData[8:6] == {2'h2, $past(relayDrive[2])}
            && readData[5:3] == {2'h1, $past(relayDrive[1])} && readData[31:12] == 20'h0)
        else $error("pair list middle wrong");
    a_all_read: assert property (@(posedge core_clk) disable iff (reset) // see RULE1
        bus.read && bus.addr == rdc_pkg::ADDR_ALL
        |=> readData == {28'h0, $past(relayDrive)})
        else $error("group read wrong");
    a_read_pending: assert property (@(posedge core_clk) disable iff (reset) // see RULE5
        bus.read && bus.addr == rdc_pkg::ADDR_PENDING
        |=> readData == {28'h0, $past(pending)})
        else $error("pending read wrong");
    a_read_idle: assert property (@(posedge core_clk) disable iff (reset) // see RULE7
        !bus.read |=> readData == 32'h0)
        else $error("read data outside slot");

    // Scenario covers
    c_commit:  cover property (@(posedge core_clk) disable iff (reset)
        panel.edit ##[1:4] panel.commit);
    c_cancel:  cover property (@(posedge core_clk) disable iff (reset)
        panel.edit ##[1:4] panel.cancel);
    c_remote:  cover property (@(posedge core_clk) disable iff (reset)
        bus.write && bus.addr == rdc_pkg::ADDR_RELAY4 && bus.wdata[0]);
    c_all:     cover property (@(posedge core_clk) disable iff (reset)
        bus.write && bus.addr == rdc_pkg::ADDR_ALL);
    c_both:    cover property (@(posedge core_clk) disable iff (reset)
        panel.commit && bus.write);
endmodule

// file: tb/rdc_coil_model.sv
/*
 Model of the relay coils behind the drive outputs.
 Assumes one coil per drive bit, switching with no delay.
*/
`timescale 1ns/1ps
module rdc_coil_model (
    input  wire logic [3:0] drive,
    output logic [3:0]      energized
);
    always_comb begin
        energized = drive;
    end
endmodule

// file: tb/tb_top.sv
/*
 Self-checking bench for the relay drive control block.
 Assumes 100 MHz core_clk and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module tb_top;
    logic                core_clk = 1'b0;
    logic                reset = 1'b1;
    rdc_pkg::rdc_bus_t   bus = '0;
    rdc_pkg::rdc_panel_t panel = '0;
    logic [31:0]         readData;
    logic [3:0]          relayDrive;
    logic [3:0]          coil;
    logic [3:0]          drv = '0;
    logic [3:0]          pend = '0;
    logic [31:0]         d;
    int                  err_total = 0;
    int                  n_compared = 0;
    int                  cyc = 0;
    int                  seed = 32'h7a78;

    rdc_relay_driver_control dut (.core_clk(core_clk), .reset(reset), .bus(bus),
        .panel(panel), .readData(readData), .relayDrive(relayDrive));
    rdc_coil_model coils (.drive(relayDrive), .energized(coil));

    initial forever #5 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wr(input logic [3:0] ad, input logic [31:0] dt);
        @(posedge core_clk) bus <= '{1'b1, 1'b0, ad, dt};
        @(posedge core_clk) bus <= '0;
        #1;
    endtask

    task automatic rd(input logic [3:0] ad, input logic [31:0] ex, input string nm);
        @(posedge core_clk) bus <= '{1'b0, 1'b1, ad, 32'h0};
        @(posedge core_clk) bus <= '0;
        #1 chk(nm, readData, ex);
    endtask

    task automatic pnl(input rdc_pkg::rdc_panel_t p);
        @(posedge core_clk) panel <= p;
        @(posedge core_clk) panel <= '0;
        #1;
    endtask

    task automatic cdrv();
        chk("relayDrive", {28'h0, relayDrive}, {28'h0, drv});
        chk("coil", {28'h0, coil}, {28'h0, drv});
    endtask

    function automatic logic [31:0] lst(input logic [3:0] v);
        lst = '0;
        for (int i = 0; i < 4; i++) begin
            lst[3*i] = v[i];
            lst[3*i+1 +: 2] = 2'(i);
        end
    endfunction

    initial begin
        repeat (20) @(posedge core_clk);
        reset <= 1'b0;
        #1 cdrv();
        rd(rdc_pkg::ADDR_LIST, lst(4'h0), "list");
        $display("test reset done");
        for (int k = 0; k < 24; k++) begin
            d = $random(seed);
            wr(4'(d[5:4]), d);
            drv[d[5:4]] = d[0];
            cdrv();
            rd(4'(d[5:4]), {31'h0, drv[d[5:4]]}, "relay");
            rd(rdc_pkg::ADDR_LIST, lst(drv), "list");
        end
        wr(rdc_pkg::ADDR_ALL, 32'h5);
        drv = 4'h5;
        wr(4'h9, 32'hf);
        wr(rdc_pkg::ADDR_PENDING, 32'ha);
        wr(rdc_pkg::ADDR_LIST, 32'ha);
        cdrv();
        rd(rdc_pkg::ADDR_ALL, {28'h0, drv}, "all");
        rd(4'h7, 32'h0, "unmapped");
        $display("test remote done");
        pend = drv;
        pnl('{1'b1, 2'd1, ~drv[1], 1'b0, 1'b0});
        pnl('{1'b1, 2'd3, ~drv[3], 1'b0, 1'b0});
        pnl('{1'b1, 2'd2, ~drv[2], 1'b0, 1'b0});
        pend[1] = ~drv[1];
        pend[2] = ~drv[2];
        pend[3] = ~drv[3];
        cdrv();
        rd(rdc_pkg::ADDR_PENDING, {28'h0, pend}, "pending");
        pnl('{1'b0, 2'd0, 1'b0, 1'b1, 1'b0});
        drv = pend;
        cdrv();
        pnl('{1'b1, 2'd0, ~drv[0], 1'b0, 1'b0});
        pnl('{1'b0, 2'd0, 1'b0, 1'b0, 1'b1});
        cdrv();
        rd(rdc_pkg::ADDR_PENDING, {28'h0, drv}, "pending");
        pnl('{1'b1, 2'd1, ~drv[1], 1'b0, 1'b1});
        rd(rdc_pkg::ADDR_PENDING, {28'h0, drv}, "pending");
        pend = drv;
        pend[2] = ~drv[2];
        pnl('{1'b1, 2'd2, ~drv[2], 1'b0, 1'b0});
        @(posedge core_clk) begin
            bus   <= '{1'b1, 1'b0, rdc_pkg::ADDR_RELAY1, {31'h0, ~pend[0]}};
            panel <= '{1'b0, 2'd0, 1'b0, 1'b1, 1'b0};
        end
        @(posedge core_clk) begin
            bus   <= '0;
            panel <= '0;
        end
        #1;
        drv = pend;
        cdrv();
        $display("test panel done");
        @(posedge core_clk) reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        drv = 4'h0;
        #1 cdrv();
        rd(rdc_pkg::ADDR_PENDING, 32'h0, "pending");
        $display("test reset again done");
        give_verdict();
    end
endmodule
